// file: design/sdac_top.sv
// Stereo DAC clock generation, rate select and audio port receiver
//
// Notes on behaviour
// - Left and right 16-bit samples are received and handed to the DAC.
// - Master mode makes frame sync and bit clock from the internal master clock.
// - Reference codes for 3.6864 to 33.6 MHz are all accepted.
// - Master mode also makes the internal DAC master clock.
// - Slave mode takes external clocks, master clock locks to one.
// - Bypass mode uses the reference input as DAC master clock.
// - Network mode picks one of four left/right slot pairs.
// - Codes 0-2: master clock 512 x frame, bit clock master / 16.
// - Codes 3-5: master clock 256 x frame, bit clock master / 8.
// - Codes 6-8: master clock 128 x frame, bit clock master / 4.
// - Codes 9-10: master clock 64 x frame, bit clock master / 2.
// - Justified format: frame sync high one word, low the next.
// - I2S format: data one bit clock later, framing unchanged.
// - Network mode: frame sync is a short frame-start pulse.
// - Frame sync and bit clock polarity are both programmable.
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sdac_top
    import sdac_pkg::*;
(
    input  wire logic        i_clk,              // 200 MHz system clock
    input  wire logic        i_sys_rst,          // Sync reset, high
    input  wire logic [4:0]  i_avs_address,      // Byte address
    input  wire logic        i_avs_read,         // Read request
    input  wire logic        i_avs_write,        // Write request
    input  wire logic [3:0]  i_avs_byteenable,   // Byte lanes
    input  wire logic [31:0] i_avs_writedata,    // Write data
    output logic      [31:0] o_avs_readdata,     // Read data
    output logic             o_avs_waitrequest,  // Stall
    input  wire logic [1:0]  i_reference_clock_input, // Reference clocks
    input  wire logic        i_frame_sync,       // Frame sync pin in
    output logic             o_frame_sync,       // Frame sync pin out
    output logic             o_frame_sync_oe,    // Frame sync drive
    input  wire logic        i_bit_clock,        // Bit clock pin in
    output logic             o_bit_clock,        // Bit clock pin out
    output logic             o_bit_clock_oe,     // Bit clock drive
    input  wire logic        i_sdata,            // Serial audio data
    output logic             o_dac_master_clock, // DAC master clock
    output logic      [15:0] o_dac_left,         // Left sample to DAC
    output logic      [15:0] o_dac_right,        // Right sample to DAC
    output logic             o_dac_load          // New pair, one cycle
);
    // ------------------------------------------------------------------
    // Registers and bus slave
    // ------------------------------------------------------------------
    logic [10:0] ctrl, next_ctrl;
    logic [6:0]  rate, next_rate;
    logic        ack, next_ack;
    logic [31:0] next_rdata;
    logic [31:0] wmask;
    logic [31:0] status;

    logic [9:0]  master_to_frame_ratio;
    logic [4:0]  nb;
    logic [3:0]  nb_half;
    logic [1:0]  family;
    logic        rate_res;
    logic        locked, next_locked;

    logic        en, inv_fs, inv_bclk, ref_sel, lock_src;
    logic [1:0]  mode, fmt, slot;
    logic        ref_ok, valid_cfg;

    assign en       = ctrl[CTRL_EN];
    assign mode     = ctrl[CTRL_MODE_LO +: 2];
    assign fmt      = ctrl[CTRL_FMT_LO +: 2];
    assign inv_fs   = ctrl[CTRL_INV_FS];
    assign inv_bclk = ctrl[CTRL_INV_BCLK];
    assign slot     = ctrl[CTRL_SLOT_LO +: 2];
    assign ref_sel  = ctrl[CTRL_REF_SEL];
    assign lock_src = ctrl[CTRL_LOCK_SRC];
    assign ref_ok   = rate[RATE_REF_LO +: 3] <= REF_FREQ_LAST;
    assign valid_cfg = en & ~rate_res & ref_ok;

    assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;

    assign status = {13'h0000, nb, master_to_frame_ratio, 1'b0, valid_cfg, locked, rate_res};

    always_comb
    begin
        next_ack   = (i_avs_read | i_avs_write) & ~ack;
        next_ctrl  = ctrl;
        next_rate  = rate;
        next_rdata = o_avs_readdata;
        if (i_avs_write && ack)
        begin
            if (i_avs_address == ADDR_CTRL)
            begin
                next_ctrl = (ctrl & ~wmask[10:0])
                          | (i_avs_writedata[10:0] & wmask[10:0]);
            end
            else if (i_avs_address == ADDR_RATE)
            begin
                next_rate = (rate & ~wmask[6:0])
                          | (i_avs_writedata[6:0] & wmask[6:0]);
            end
        end
        if (i_avs_read && !ack)
        begin
            if (i_avs_address == ADDR_CTRL)
                next_rdata = {21'h000000, ctrl};
            else if (i_avs_address == ADDR_RATE)
                next_rdata = {25'h0000000, rate};
            else if (i_avs_address == ADDR_STATUS)
                next_rdata = status;
            else if (i_avs_address == ADDR_LEFT)
                next_rdata = {16'h0000, o_dac_left};
            else if (i_avs_address == ADDR_RIGHT)
                next_rdata = {16'h0000, o_dac_right};
            else
                next_rdata = 32'h00000000;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            ctrl           <= CTRL_RESET;
            rate           <= RATE_RESET;
            ack            <= 1'b0;
            o_avs_readdata <= 32'h00000000;
        end
        else
        begin
            ctrl           <= next_ctrl;
            rate           <= next_rate;
            ack            <= next_ack;
            o_avs_readdata <= next_rdata;
        end
    end

    sdac_rate_table u_rate (
        .i_clk      (i_clk),
        .i_sys_rst  (i_sys_rst),
        .i_code     (rate[RATE_CODE_LO +: 4]),
        .o_nfs      (master_to_frame_ratio),
        .o_nb       (nb),
        .o_nb_half  (nb_half),
        .o_family   (family),
        .o_reserved (rate_res)
    );

    // ------------------------------------------------------------------
    // Master clock: accumulator stands in for the PLL
    // ------------------------------------------------------------------
    logic [31:0] acc, next_acc, inc;
    logic [32:0] acc_sum;
    logic        ref_s, ref_d, next_ref_d;
    logic        mcl_q, next_mcl;
    logic        mcl_rise;
    logic        ext_bclk, ext_fs, bclk_d, fs_d, next_bclk_d, next_fs_d;
    logic        ext_bclk_rise, ext_fs_rise, lock_edge;

    assign ref_s    = i_reference_clock_input[ref_sel];
    assign ext_bclk = i_bit_clock ^ inv_bclk;
    assign ext_fs   = i_frame_sync ^ inv_fs;
    assign ext_bclk_rise = ext_bclk & ~bclk_d;
    assign ext_fs_rise   = ext_fs & ~fs_d;
    assign lock_edge = lock_src ? ext_bclk_rise : ext_fs_rise;
    assign inc = (family == 2'h0) ? NCO_INC_A
               : ((family == 2'h1) ? NCO_INC_B : NCO_INC_C);
    assign acc_sum = {1'b0, acc} + {1'b0, inc};

    always_comb
    begin
        next_ref_d  = ref_s;
        next_bclk_d = ext_bclk;
        next_fs_d   = ext_fs;
        next_acc    = acc_sum[31:0];
        next_mcl    = mcl_q;
        next_locked = locked;
        mcl_rise    = 1'b0;
        if (!valid_cfg)
        begin
            next_acc    = 32'h00000000;
            next_mcl    = 1'b0;
            next_locked = 1'b0;
        end
        else if (mode == SDAC_BYPASS)
        begin
            next_mcl    = ref_s;
            mcl_rise    = ref_s & ~ref_d;
            next_locked = 1'b1;
        end
        else
        begin
            if (mode == SDAC_SLAVE && lock_edge)
            begin
                next_acc    = 32'h00000000;
                next_locked = 1'b1;
            end
            else if (mode != SDAC_SLAVE)
            begin
                next_locked = 1'b1;
            end
            if (acc_sum[32])
            begin
                next_mcl = ~mcl_q;
                mcl_rise = ~mcl_q;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            acc    <= 32'h00000000;
            mcl_q  <= 1'b0;
            ref_d  <= 1'b0;
            bclk_d <= 1'b0;
            fs_d   <= 1'b0;
            locked <= 1'b0;
        end
        else
        begin
            acc    <= next_acc;
            mcl_q  <= next_mcl;
            ref_d  <= next_ref_d;
            bclk_d <= next_bclk_d;
            fs_d   <= next_fs_d;
            locked <= next_locked;
        end
    end

    // ------------------------------------------------------------------
    // Bit clock and frame sync generation
    // ------------------------------------------------------------------
    logic [3:0] hc, next_hc;
    logic [4:0] bi, next_bi;
    logic       bclk_q, next_bclk, fs_q, next_fs;
    logic       int_strobe;
    logic       drive;

    always_comb
    begin
        next_hc    = hc;
        next_bi    = bi;
        next_bclk  = bclk_q;
        next_fs    = fs_q;
        int_strobe = 1'b0;
        if (!valid_cfg)
        begin
            next_hc   = 4'h0;
            next_bi   = FRAME_LAST;
            next_bclk = 1'b0;
            next_fs   = 1'b0;
        end
        else if (mcl_rise)
        begin
            if (hc >= nb_half - 4'h1)
            begin
                next_hc    = 4'h0;
                next_bclk  = ~bclk_q;
                int_strobe = ~bclk_q;
                // Data and sync move on the falling edge
                if (bclk_q)
                begin
                    next_bi = bi + 5'h01;
                    if (fmt == SDAC_FMT_NET)
                        next_fs = (next_bi == 5'h00);
                    else
                        next_fs = next_bi < 5'(WORD_BITS);
                end
            end
            else
            begin
                next_hc = hc + 4'h1;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            hc     <= 4'h0;
            bi     <= FRAME_LAST;
            bclk_q <= 1'b0;
            fs_q   <= 1'b0;
        end
        else
        begin
            hc     <= next_hc;
            bi     <= next_bi;
            bclk_q <= next_bclk;
            fs_q   <= next_fs;
        end
    end

    // Bypass still generates the port clocks, from the reference
    assign drive              = (mode != SDAC_SLAVE);
    assign o_bit_clock_oe     = drive;
    assign o_frame_sync_oe    = drive;
    assign o_bit_clock        = bclk_q ^ inv_bclk;
    assign o_frame_sync       = fs_q ^ inv_fs;
    assign o_dac_master_clock = mcl_q;

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    sdac_slot_rx u_rx (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_strobe  (drive ? int_strobe : (en & ext_bclk_rise)),
        .i_fs      (drive ? fs_q : ext_fs),
        .i_sdata   (i_sdata),
        .i_fmt     (fmt),
        .i_slot    (slot),
        .o_left    (o_dac_left),
        .o_right   (o_dac_right),
        .o_valid   (o_dac_load)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [4:0] fs_len;
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || (fs_q && !$past(fs_q)))
            fs_len <= 5'h00;
        else if (fs_q && bclk_q && !next_bclk)
            fs_len <= fs_len + 5'h01;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_fs_word;
        $fell(fs_q) && fmt != SDAC_FMT_NET && valid_cfg;
    endsequence

    chk_low_rates: assert property (
        $past(rate[3:0]) <= 4'h2 && !$past(i_sys_rst)
        |-> master_to_frame_ratio == 10'd512 && nb == 5'd16)
        else $error("low rate divisors wrong");
    chk_mid_rates: assert property (
        $past(rate[3:0]) inside {4'h3, 4'h4, 4'h5} && !$past(i_sys_rst)
        |-> master_to_frame_ratio == 10'd256 && nb == 5'd8)
        else $error("mid rate divisors wrong");
    chk_high_rates: assert property (
        $past(rate[3:0]) inside {4'h6, 4'h7, 4'h8} && !$past(i_sys_rst)
        |-> master_to_frame_ratio == 10'd128 && nb == 5'd4)
        else $error("high rate divisors wrong");
    chk_top_rates: assert property (
        $past(rate[3:0]) inside {4'h9, 4'hA} && !$past(i_sys_rst)
        |-> master_to_frame_ratio == 10'd64 && nb == 5'd2)
        else $error("top rate divisors wrong");
    chk_reserved_static: assert property (
        rate_res [*3] |-> !bclk_q && !fs_q && !mcl_q)
        else $error("clocks run on reserved code");
    chk_fs_word_len: assert property (
        s_fs_word |-> fs_len == 5'(WORD_BITS))
        else $error("frame sync word length wrong");
    chk_net_pulse: assert property (
        $fell(fs_q) && fmt == SDAC_FMT_NET && valid_cfg |-> fs_len == 5'h01)
        else $error("network frame pulse not one bit");
    chk_slave_release: assert property (
        mode == SDAC_SLAVE |-> !o_bit_clock_oe && !o_frame_sync_oe)
        else $error("slave mode drives port clocks");
    chk_bypass_mcl: assert property (
        mode == SDAC_BYPASS && valid_cfg && $stable(ctrl)
        |=> o_dac_master_clock == $past(ref_s))
        else $error("bypass master clock not reference");
    chk_master_mcl: assert property (
        mode == SDAC_MASTER && valid_cfg [*8] |-> ##[0:25] $changed(mcl_q))
        else $error("master clock stalled");
    chk_bus_answer: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest)
        else $error("bus answer late");

endmodule
`default_nettype wire

// file: design/sdac_pkg.sv
// Constants and types of the stereo DAC clock and rate select block
package sdac_pkg;

    // ------------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------------
    localparam longint CLK_HZ        = 64'd200000000;
    localparam longint MCL_A_HZ      = 64'd4096000;
    localparam longint MCL_B_HZ      = 64'd5644800;
    localparam longint MCL_C_HZ      = 64'd6144000;
    // Accumulator wraps at twice the master clock; one toggle per wrap
    localparam logic [31:0] NCO_INC_A =
        32'((MCL_A_HZ * 64'd2 * 64'h100000000) / CLK_HZ);
    localparam logic [31:0] NCO_INC_B =
        32'((MCL_B_HZ * 64'd2 * 64'h100000000) / CLK_HZ);
    localparam logic [31:0] NCO_INC_C =
        32'((MCL_C_HZ * 64'd2 * 64'h100000000) / CLK_HZ);

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_CTRL   = 5'h00;
    localparam logic [4:0] ADDR_RATE   = 5'h04;
    localparam logic [4:0] ADDR_STATUS = 5'h08;
    localparam logic [4:0] ADDR_LEFT   = 5'h0C;
    localparam logic [4:0] ADDR_RIGHT  = 5'h10;

    localparam int CTRL_EN       = 0;
    localparam int CTRL_MODE_LO  = 1;
    localparam int CTRL_FMT_LO   = 3;
    localparam int CTRL_INV_FS   = 5;
    localparam int CTRL_INV_BCLK = 6;
    localparam int CTRL_SLOT_LO  = 7;
    localparam int CTRL_REF_SEL  = 9;
    localparam int CTRL_LOCK_SRC = 10;
    localparam logic [10:0] CTRL_RESET = 11'h000;

    localparam int RATE_CODE_LO = 0;
    localparam int RATE_REF_LO  = 4;
    localparam logic [6:0] RATE_RESET = 7'h18;
    localparam logic [2:0] REF_FREQ_LAST = 3'h6;

    localparam int STAT_RESERVED = 0;
    localparam int STAT_LOCKED   = 1;
    localparam int STAT_RUNNING  = 2;
    localparam int STAT_NFS_LO   = 4;
    localparam int STAT_NB_LO    = 14;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int          WORD_BITS  = 16;
    localparam logic [4:0]  FRAME_LAST = 5'h1F;

    typedef enum logic [1:0] {
        SDAC_MASTER,
        SDAC_SLAVE,
        SDAC_BYPASS
    } sdac_mode_e;

    typedef enum logic [1:0] {
        SDAC_FMT_MSB,
        SDAC_FMT_I2S,
        SDAC_FMT_NET
    } sdac_fmt_e;

endpackage

// file: design/sdac_rate_table.sv
// Rate code to divisor lookup, registered
`timescale 1ns/1ps
`default_nettype none
module sdac_rate_table
    import sdac_pkg::*;
(
    input  wire logic        i_clk,       // System clock
    input  wire logic        i_sys_rst,   // Sync reset, high
    input  wire logic [3:0]  i_code,      // Rate code
    output logic      [9:0]  o_nfs,       // Master to frame ratio
    output logic      [4:0]  o_nb,        // Master to bit ratio
    output logic      [3:0]  o_nb_half,   // Half of master to bit ratio
    output logic      [1:0]  o_family,    // Master clock family
    output logic             o_reserved   // Code is reserved
);
    logic [9:0] next_nfs;
    logic [4:0] next_nb;
    logic [1:0] next_family;
    logic       next_reserved;

    always_comb
    begin
        next_reserved = 1'b0;
        next_family   = 2'(i_code % 4'h3);
        if (i_code <= 4'h2)
        begin
            next_nfs = 10'd512;
            next_nb  = 5'd16;
        end
        else if (i_code <= 4'h5)
        begin
            next_nfs = 10'd256;
            next_nb  = 5'd8;
        end
        else if (i_code <= 4'h8)
        begin
            next_nfs = 10'd128;
            next_nb  = 5'd4;
        end
        else if (i_code <= 4'hA)
        begin
            next_nfs    = 10'd64;
            next_nb     = 5'd2;
            next_family = (i_code == 4'h9) ? 2'h0 : 2'h2;
        end
        else
        begin
            next_nfs      = 10'd0;
            next_nb       = 5'd0;
            next_reserved = 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_nfs      <= 10'd0;
            o_nb       <= 5'd0;
            o_family   <= 2'h0;
            o_reserved <= 1'b1;
        end
        else
        begin
            o_nfs      <= next_nfs;
            o_nb       <= next_nb;
            o_family   <= next_family;
            o_reserved <= next_reserved;
        end
    end

    assign o_nb_half = o_nb[4:1];

endmodule
`default_nettype wire

// file: design/sdac_slot_rx.sv
// Serial sample receiver with format and slot selection
`timescale 1ns/1ps
`default_nettype none
module sdac_slot_rx
    import sdac_pkg::*;
(
    input  wire logic        i_clk,       // System clock
    input  wire logic        i_sys_rst,   // Sync reset, high
    input  wire logic        i_strobe,    // Bit clock sampling edge
    input  wire logic        i_fs,        // Frame sync, true polarity
    input  wire logic        i_sdata,     // Serial data
    input  wire logic [1:0]  i_fmt,       // Frame format
    input  wire logic [1:0]  i_slot,      // Slot pair in network mode
    output logic      [15:0] o_left,      // Left sample
    output logic      [15:0] o_right,     // Right sample
    output logic             o_valid      // Pair complete, one cycle
);
    logic        fs_prev, next_fs_prev;
    logic [6:0]  idx, next_idx;
    logic [15:0] shift, next_shift;
    logic [15:0] next_left, next_right;
    logic        next_valid;
    logic        frame_start;
    logic [6:0]  cur_idx, pos;
    logic [1:0]  pair;

    always_comb
    begin
        next_fs_prev = fs_prev;
        next_idx     = idx;
        next_shift   = shift;
        next_left    = o_left;
        next_right   = o_right;
        next_valid   = 1'b0;
        // Short pulse in network mode, level edge otherwise
        frame_start  = (i_fmt == SDAC_FMT_NET) ? i_fs
                                               : (i_fs & ~fs_prev);
        cur_idx      = frame_start ? 7'h00
                     : ((idx == 7'h7F) ? idx : idx + 7'h01);
        // Delayed format: this bit belongs to the previous position
        pos          = (i_fmt == SDAC_FMT_I2S) ? idx : cur_idx;
        pair         = (i_fmt == SDAC_FMT_NET) ? i_slot : 2'h0;
        if (i_strobe)
        begin
            next_fs_prev = i_fs;
            next_idx     = cur_idx;
            next_shift   = {shift[14:0], i_sdata};
            if (pos[3:0] == 4'hF && pos[6:4] == {pair, 1'b0})
            begin
                next_left = next_shift;
            end
            else if (pos[3:0] == 4'hF && pos[6:4] == {pair, 1'b1})
            begin
                next_right = next_shift;
                next_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            fs_prev <= 1'b0;
            idx     <= 7'h7F;
            shift   <= 16'h0000;
            o_left  <= 16'h0000;
            o_right <= 16'h0000;
            o_valid <= 1'b0;
        end
        else
        begin
            fs_prev <= next_fs_prev;
            idx     <= next_idx;
            shift   <= next_shift;
            o_left  <= next_left;
            o_right <= next_right;
            o_valid <= next_valid;
        end
    end

endmodule
`default_nettype wire

// file: bench/sdac_ssi_model.sv
// Processor serial audio port model: sends one fixed left/right frame
`timescale 1ns/1ps
`default_nettype none
module sdac_ssi_model
(
    input  wire logic        i_clk,   // System clock
    input  wire logic        i_fs,    // Frame sync from device
    input  wire logic        i_bclk,  // Bit clock from device
    input  wire logic [31:0] i_word,  // Left word then right word
    input  wire logic        i_i2s,   // Data one bit clock later
    output logic             o_sdata  // Serial data to device
);
    logic       pb = 1'b0;
    logic       pf = 1'b0;
    logic [4:0] n  = 5'h00;
    logic [4:0] k;
    // Launch on falling bit clock so data is steady at the rising edge
    always @(posedge i_clk)
    begin
        pb <= i_bclk;
        if (pb && !i_bclk)
        begin
            k = (i_fs && !pf) ? 5'h00 : n + 5'h01;
            pf <= i_fs;
            n <= k;
            // Delayed format sends the previous position's bit
            o_sdata <= i_word[~(k - {4'h0, i_i2s})];
        end
    end
endmodule
`default_nettype wire

// file: bench/tb.sv
// Self-checking testbench of the stereo DAC clock and rate select block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sdac_pkg::*;
    logic        clk = 0, rst = 1, rd = 0, wr = 0;
    logic [4:0]  ad = 0;
    logic [31:0] wd = 0, q, rq;
    logic [1:0]  refc = 0;
    logic        sd, fs, fso, bc, bco, ld, wq, b0, mc;
    logic        i2s = 0;
    logic [15:0] dl, dr;
    int          n_fail = 0, total_checks = 0, t;
    localparam logic [31:0] WORD = 32'hA5C31E69;
    // Rate code, master/frame ratio, master/bit ratio; zero ratios = reserved
    logic [18:0] rows [13] = '{19'h04010, 19'h0C010, 19'h14010, 19'h1A008,
        19'h22008, 19'h2A008, 19'h31004, 19'h39004, 19'h41004, 19'h48802,
        19'h50802, 19'h58000, 19'h78000};
    always #2.5 clk = ~clk;
    // Bit 1 is the master clock in bypass, a fixed multiple of the frame
    always @(posedge clk) refc <= refc + 2'h1;
    // Port clocks looped back: in slave mode they come in as external ones
    sdac_top uut (.i_clk(clk), .i_sys_rst(rst), .i_avs_address(ad),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(4'hF),
        .i_avs_writedata(wd), .o_avs_readdata(rq), .o_avs_waitrequest(wq),
        .i_reference_clock_input(refc), .i_frame_sync(fs),
        .o_frame_sync(fs), .o_frame_sync_oe(fso), .i_bit_clock(bc),
        .o_bit_clock(bc), .o_bit_clock_oe(bco), .i_sdata(sd),
        .o_dac_master_clock(mc), .o_dac_left(dl), .o_dac_right(dr),
        .o_dac_load(ld));
    sdac_ssi_model peer (.i_clk(clk), .i_fs(fs), .i_bclk(bc),
        .i_word(WORD), .i_i2s(i2s), .o_sdata(sd));
    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        ad <= a;
        wd <= d;
        t = 0;
        do @(posedge clk); while (wq !== 1'b0 && ++t < 99);
        q = rq;
        if (wq !== 1'b0)
        begin
            n_fail++;
            $display("[FAIL] bus answer exp 0 got %b", wq);
        end
        wr <= 0;
        rd <= 0;
    endtask
    // Second pair after a change, so the first frame may be a partial one
    task automatic rx_pair;
        t = 0;
        repeat (2) do @(negedge clk); while (ld !== 1'b1 && ++t < 20000);
        chk("load", 1, ld);
        chk("left", WORD[31:16], dl);
        chk("right", WORD[15:0], dr);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clk);
        n_fail++;
        results;
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 0;
        bus(0, ADDR_RATE, 0);
        chk("rate reset", {25'h0, RATE_RESET}, q);
        bus(0, ADDR_CTRL, 0);
        chk("ctrl reset", {21'h0, CTRL_RESET}, q);
        for (int i = 0; i < 13; i++)
        begin
            bus(1, ADDR_RATE, {28'h0, rows[i][18:15]});
            bus(0, ADDR_STATUS, 0);
            b0 = rows[i][14:0] == 15'h0;
            chk("status", {rows[i][14:0], b0},
                {q[13:4], q[18:14], q[0]});
        end
        bus(0, 5'h14, 0);
        chk("unmapped", 0, q);
        bus(1, ADDR_RATE, 32'hA);
        bus(1, ADDR_CTRL, 32'h60);
        @(negedge clk);
        chk("inverted idle", 2'h3, {fs, bc});
        bus(1, ADDR_CTRL, 32'h1);
        rx_pair;
        bus(1, ADDR_CTRL, 32'h9);
        i2s <= 1'b1;
        rx_pair;
        // Disabled in between: a format change mid-frame cuts a sync pulse
        bus(1, ADDR_CTRL, 32'h10);
        i2s <= 1'b0;
        bus(1, ADDR_CTRL, 32'h11);
        rx_pair;
        bus(1, ADDR_RATE, 32'hB);
        repeat (20) @(negedge clk);
        b0 = bc;
        t = 0;
        repeat (300) @(negedge clk) t += int'(bc !== b0);
        chk("clock held", 0, t);
        bus(1, ADDR_CTRL, 32'h3);
        @(negedge clk);
        chk("slave drive", 2'h0, {fso, bco});
        bus(1, ADDR_RATE, 32'hA);
        rx_pair;
        bus(0, ADDR_STATUS, 0);
        chk("locked", 1, q[1]);
        bus(1, ADDR_CTRL, 32'h205);
        rx_pair;
        t = 0;
        b0 = mc;
        repeat (64) @(negedge clk)
        begin
            t += int'(mc !== b0);
            b0 = mc;
        end
        chk("bypass mcl", 32, t);
        @(posedge clk);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        bus(0, ADDR_RATE, 0);
        chk("rate after reset", {25'h0, RATE_RESET}, q);
        chk("left after reset", 0, dl);
        results;
    end
endmodule
`default_nettype wire
